/* odc_pkg.sv */
// Constants shared by the octal converter configuration control block
package odc_pkg;

	// Sizes
	localparam int NUM_CHAN   = 8;
	localparam int DATA_W     = 12;
	localparam int ADDR_W     = 5;
	localparam int WORD_W     = 16;
	localparam int CHAN_SEL_W = 3;

	// Register address codes; bits [4:3] pick the bank, [2:0] the channel
	localparam logic [4:0] ADDR_CONFIG    = 5'h00;
	localparam logic [4:0] ADDR_DATA_BASE = 5'h08;
	localparam logic [4:0] ADDR_ZERO_BASE = 5'h10;
	localparam logic [4:0] ADDR_GAIN_BASE = 5'h18;

	// Configuration register field positions
	localparam int CFG_READ_SEL_BIT   = 15;
	localparam int CFG_SYNC_LOAD_BIT  = 14;
	localparam int CFG_SOFT_RESET_BIT = 13;
	localparam int CFG_PD_A_BIT       = 12;
	localparam int CFG_PD_B_BIT       = 11;
	localparam int CFG_CAL_EN_BIT     = 10;

	// 12-bit words sit in D15:D4 of a 16-bit frame word
	localparam int WORD_DATA_LSB = 4;

	// Reset values, and the top of the data range
	localparam logic [11:0] CFG_RESET_VAL  = 12'h800;
	localparam logic        READ_SEL_RESET = 1'b1;
	localparam logic [11:0] GAIN_RESET_VAL = 12'h800;
	localparam logic [11:0] ZERO_RESET_VAL = 12'h000;
	localparam logic [11:0] DATA_RESET_VAL = 12'h000;
	localparam logic [11:0] DATA_MAX_VAL   = 12'hFFF;

	// Gain of 800h is unity: product is scaled down by this shift
	localparam int GAIN_SHIFT = 11;

endpackage : odc_pkg

/* odc_corrector.sv */
// Two-stage gain and zero correction pipeline for one channel word
`timescale 1ns/1ps
`default_nettype none

module odc_corrector (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Job in
	input  wire logic        start_i,
	input  wire logic [2:0]  chan_i,
	input  wire logic [11:0] raw_i,
	input  wire logic [11:0] gain_i,
	input  wire logic [11:0] zero_i,
	// Result out
	output logic             busy_o,
	output logic             done_o,
	output logic [2:0]       chan_o,
	output logic [11:0]      result_o
);

	logic        s1_vld_reg,  s1_vld_next;
	logic [2:0]  s1_chan_reg, s1_chan_next;
	logic [12:0] s1_scl_reg,  s1_scl_next;
	logic [11:0] s1_zero_reg, s1_zero_next;
	logic        s2_vld_reg,  s2_vld_next;
	logic [2:0]  s2_chan_reg, s2_chan_next;
	logic [11:0] s2_res_reg,  s2_res_next;
	logic [23:0] product;
	logic [14:0] sum;

	always_comb begin
		product      = 24'(raw_i) * 24'(gain_i);
		s1_vld_next  = start_i;
		s1_chan_next = chan_i;
		s1_scl_next  = product[odc_pkg::GAIN_SHIFT +: 13];
		s1_zero_next = zero_i;
		// Zero is signed; widen so overflow and underflow are both seen
		sum = {2'h0, s1_scl_reg} + {{3{s1_zero_reg[11]}}, s1_zero_reg};
		s2_vld_next  = s1_vld_reg;
		s2_chan_next = s1_chan_reg;
		if (sum[14]) begin
			s2_res_next = odc_pkg::DATA_RESET_VAL;
		end else if (sum[13:12] != 2'h0) begin
			s2_res_next = odc_pkg::DATA_MAX_VAL;
		end else begin
			s2_res_next = sum[11:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_vld_reg  <= 1'b0;
			s1_chan_reg <= 3'h0;
			s1_scl_reg  <= 13'h0000;
			s1_zero_reg <= 12'h000;
			s2_vld_reg  <= 1'b0;
			s2_chan_reg <= 3'h0;
			s2_res_reg  <= 12'h000;
		end else begin
			s1_vld_reg  <= s1_vld_next;
			s1_chan_reg <= s1_chan_next;
			s1_scl_reg  <= s1_scl_next;
			s1_zero_reg <= s1_zero_next;
			s2_vld_reg  <= s2_vld_next;
			s2_chan_reg <= s2_chan_next;
			s2_res_reg  <= s2_res_next;
		end
	end

	assign busy_o   = s1_vld_reg | s2_vld_reg;
	assign done_o   = s2_vld_reg;
	assign chan_o   = s2_chan_reg;
	assign result_o = s2_res_reg;

endmodule : odc_corrector

`default_nettype wire

/* odc_latch_bank.sv */
// Output latches of the eight channels, each loaded by its own mask bit
`timescale 1ns/1ps
`default_nettype none

module odc_latch_bank (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Load request
	input  wire logic [7:0]  load_mask_i,
	input  wire logic [95:0] data_i,
	// Latched values
	output logic      [95:0] latch_o
);

	genvar g;
	generate
		for (g = 0; g < odc_pkg::NUM_CHAN; g++) begin : g_chan
			logic [11:0] latch_reg, latch_next;
			always_comb begin
				latch_next = load_mask_i[g] ? data_i[g*12 +: 12] : latch_reg;
			end
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					latch_reg <= odc_pkg::DATA_RESET_VAL;
				end else begin
					latch_reg <= latch_next;
				end
			end
			assign latch_o[g*12 +: 12] = latch_reg;
		end
	endgenerate

endmodule : odc_latch_bank

`default_nettype wire

/* odc_config_ctrl.sv */
// Configuration register, channel registers and latch update control
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Readback gives input register when select is 0, data register when 1.
// - Correction on: input register keeps raw word, data register result.
// - Sync load bit with pin high loads accessed latches after correction.
// - Only channels written since the last load event are reloaded.
// - Sync load bit clears itself once its latch update is done.
// - Correction off: latches update right after the sync load bit is set.
// - Writes of the sync load bit are ignored while the load pin is low.
// - Writing the software reset bit resets the device like the reset input.
// - Software reset bit reads back as 0 once reset is over.
// - Group A power-down bit powers down channels 0 to 3.
// - Group B power-down bit powers down channels 4 to 7.
// - Register port keeps working while any group is powered down.
// - Calibration on: written word corrected by gain and zero, then latched.
// - Calibration off: written word goes straight to the data register.
// - Reserved and don't-care bits ignore writes and read as 0.
// - Configuration resets to its default: readback select 1, other bits 0.
// - Gain registers are 12-bit unsigned, reset to mid-scale.
// - Zero registers are 12-bit two's complement, reset to zero.
module odc_config_ctrl (
	// Clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	// Register port from the serial frame decoder
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [4:0]  REG_ADDR_I,
	input  wire logic [15:0] REG_WDATA_I,
	output logic      [15:0] REG_RDATA_O,
	output logic             REG_RVALID_O,
	// Asynchronous latch load pin
	input  wire logic        ASYNC_LATCH_LOAD_PIN_I,
	// Channel outputs
	output logic      [95:0] LATCH_DATA_O,
	output logic             POWER_DOWN_GROUP_A_O,
	output logic             POWER_DOWN_GROUP_B_O
);

	localparam int NCH = odc_pkg::NUM_CHAN;
	localparam int LSB = odc_pkg::WORD_DATA_LSB;

	// Software reset pulse; it ends on its own after one cycle and is reset only by the reset input
	logic        soft_rst_reg, soft_rst_next;
	logic        rst_all;

	// Load pin synchroniser and edge detect
	logic        pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic        pin_s1_next, pin_s2_next, pin_s3_next;
	logic        pin_high, pin_fall;

	// Configuration fields
	logic        read_sel_reg,    read_sel_next;
	logic        sync_load_reg,   sync_load_next;
	logic        pd_group_a_reg,  pd_group_a_next;
	logic        pd_group_b_reg,  pd_group_b_next;
	logic        cal_enable_reg,  cal_enable_next;

	// Channel register arrays
	logic [11:0] input_reg  [NCH];
	logic [11:0] input_next [NCH];
	logic [11:0] data_reg   [NCH];
	logic [11:0] data_next  [NCH];
	logic [11:0] gain_reg   [NCH];
	logic [11:0] gain_next  [NCH];
	logic [11:0] zero_reg   [NCH];
	logic [11:0] zero_next  [NCH];
	logic [7:0]  accessed_reg, accessed_next;

	// Read port
	logic [15:0] rdata_reg,  rdata_next;
	logic        rvalid_reg, rvalid_next;

	// Decode
	logic        wr_cfg, wr_data, wr_zero, wr_gain;
	logic [2:0]  chan;
	logic [1:0]  bank;
	logic [11:0] wword;
	logic [7:0]  written_mask;
	logic [7:0]  load_mask;
	logic        update_fire;
	logic        load_event;
	logic [95:0] data_flat;

	// Correction engine
	logic        eng_start, eng_busy, eng_done;
	logic [2:0]  eng_chan;
	logic [11:0] eng_result;

	assign rst_all = RST_I | soft_rst_reg;

	// Only the second stage reads the first, so a metastable first stage
	// never reaches the edge detect or the load logic
	always_comb begin
		pin_s1_next = ASYNC_LATCH_LOAD_PIN_I;
		pin_s2_next = pin_s1_reg;
		pin_s3_next = pin_s2_reg;
	end

	// Stages reset to the idle high level so no false fall follows reset
	always_ff @(posedge CLK_SYS_I) begin
		if (rst_all) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			pin_s3_reg <= 1'b1;
		end else begin
			pin_s1_reg <= pin_s1_next;
			pin_s2_reg <= pin_s2_next;
			pin_s3_reg <= pin_s3_next;
		end
	end

	assign pin_high = pin_s2_reg;
	assign pin_fall = pin_s3_reg & ~pin_s2_reg;

	// Address decode; every bank stays reachable in power-down
	assign bank    = REG_ADDR_I[4:3];
	assign chan    = REG_ADDR_I[2:0];
	assign wword   = REG_WDATA_I[LSB +: 12];
	assign wr_cfg  = REG_WR_I && (REG_ADDR_I == odc_pkg::ADDR_CONFIG);
	assign wr_data = REG_WR_I && (bank == odc_pkg::ADDR_DATA_BASE[4:3]);
	assign wr_zero = REG_WR_I && (bank == odc_pkg::ADDR_ZERO_BASE[4:3]);
	assign wr_gain = REG_WR_I && (bank == odc_pkg::ADDR_GAIN_BASE[4:3]);
	assign written_mask = wr_data ? (8'h01 << chan) : 8'h00;

	// Corrected word starts down the pipeline only when calibration is on
	assign eng_start = wr_data & cal_enable_reg;

	// Wait until no correction is in flight, including one starting now
	assign update_fire = sync_load_reg & ~eng_busy & ~eng_start;
	assign load_event  = update_fire | pin_fall;
	// Channels not written since the last load keep their latch
	assign load_mask   = load_event ? accessed_reg : 8'h00;

	// Gain and zero are taken with the write; later edits miss a word in flight
	odc_corrector u_corrector (
		.clk_i    (CLK_SYS_I),
		.rst_i    (rst_all),
		.start_i  (eng_start),
		.chan_i   (chan),
		.raw_i    (wword),
		.gain_i   (gain_reg[chan]),
		.zero_i   (zero_reg[chan]),
		.busy_o   (eng_busy),
		.done_o   (eng_done),
		.chan_o   (eng_chan),
		.result_o (eng_result)
	);

	always_comb begin
		// Masked while the pulse runs, so the pulse never lasts two cycles
		soft_rst_next   = wr_cfg & REG_WDATA_I[odc_pkg::CFG_SOFT_RESET_BIT]
		                & ~soft_rst_reg;
		read_sel_next   = read_sel_reg;
		pd_group_a_next = pd_group_a_reg;
		pd_group_b_next = pd_group_b_reg;
		cal_enable_next = cal_enable_reg;
		if (wr_cfg) begin
			read_sel_next   = REG_WDATA_I[odc_pkg::CFG_READ_SEL_BIT];
			pd_group_a_next = REG_WDATA_I[odc_pkg::CFG_PD_A_BIT];
			pd_group_b_next = REG_WDATA_I[odc_pkg::CFG_PD_B_BIT];
			cal_enable_next = REG_WDATA_I[odc_pkg::CFG_CAL_EN_BIT];
		end
		// Pin low drops the write rather than holding it for later
		// A new set beats the self clear of a finished update
		if (wr_cfg && REG_WDATA_I[odc_pkg::CFG_SYNC_LOAD_BIT] && pin_high) begin
			sync_load_next = 1'b1;
		end else if (update_fire) begin
			sync_load_next = 1'b0;
		end else begin
			sync_load_next = sync_load_reg;
		end
		// A write in the load cycle keeps its flag for the next load
		accessed_next = (accessed_reg & ~load_mask) | written_mask;
	end

	// Both registers are always kept; the readback select only steers reads
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			input_next[i] = input_reg[i];
			data_next[i]  = data_reg[i];
			gain_next[i]  = gain_reg[i];
			zero_next[i]  = zero_reg[i];
			if (wr_data && chan == 3'(i)) begin
				input_next[i] = wword;
			end
			if (eng_done && eng_chan == 3'(i)) begin
				data_next[i] = eng_result;
			end
			// Direct write is newer than a result still in flight
			if (wr_data && !cal_enable_reg && chan == 3'(i)) begin
				data_next[i] = wword;
			end
			if (wr_gain && chan == 3'(i)) begin
				gain_next[i] = wword;
			end
			if (wr_zero && chan == 3'(i)) begin
				zero_next[i] = wword;
			end
		end
	end

	// Read answer is registered and stands for one cycle only
	always_comb begin
		rvalid_next = REG_RD_I;
		rdata_next  = 16'h0000;
		if (REG_RD_I) begin
			if (REG_ADDR_I == odc_pkg::ADDR_CONFIG) begin
				rdata_next[odc_pkg::CFG_READ_SEL_BIT]  = read_sel_reg;
				rdata_next[odc_pkg::CFG_SYNC_LOAD_BIT] = sync_load_reg;
				rdata_next[odc_pkg::CFG_PD_A_BIT]      = pd_group_a_reg;
				rdata_next[odc_pkg::CFG_PD_B_BIT]      = pd_group_b_reg;
				rdata_next[odc_pkg::CFG_CAL_EN_BIT]    = cal_enable_reg;
				// Software reset bit always reads 0
			end else if (bank == odc_pkg::ADDR_DATA_BASE[4:3]) begin
				rdata_next[LSB +: 12] = read_sel_reg ? data_reg[chan]
				                                     : input_reg[chan];
			end else if (bank == odc_pkg::ADDR_ZERO_BASE[4:3]) begin
				rdata_next[LSB +: 12] = zero_reg[chan];
			end else if (bank == odc_pkg::ADDR_GAIN_BASE[4:3]) begin
				rdata_next[LSB +: 12] = gain_reg[chan];
			end
		end
	end

	// The pulse sits outside the reset it drives, so it can end on its own
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= soft_rst_next;
		end
	end

	// Software reset clears every field exactly as the reset input does
	always_ff @(posedge CLK_SYS_I) begin
		if (rst_all) begin
			read_sel_reg   <= odc_pkg::READ_SEL_RESET;
			sync_load_reg  <= odc_pkg::CFG_RESET_VAL[odc_pkg::CFG_SYNC_LOAD_BIT - LSB];
			pd_group_a_reg <= odc_pkg::CFG_RESET_VAL[odc_pkg::CFG_PD_A_BIT - LSB];
			pd_group_b_reg <= odc_pkg::CFG_RESET_VAL[odc_pkg::CFG_PD_B_BIT - LSB];
			cal_enable_reg <= odc_pkg::CFG_RESET_VAL[odc_pkg::CFG_CAL_EN_BIT - LSB];
			accessed_reg   <= 8'h00;
			rdata_reg      <= 16'h0000;
			rvalid_reg     <= 1'b0;
		end else begin
			read_sel_reg   <= read_sel_next;
			sync_load_reg  <= sync_load_next;
			pd_group_a_reg <= pd_group_a_next;
			pd_group_b_reg <= pd_group_b_next;
			cal_enable_reg <= cal_enable_next;
			accessed_reg   <= accessed_next;
			rdata_reg      <= rdata_next;
			rvalid_reg     <= rvalid_next;
		end
	end

	// Gain returns to unity and zero to no offset on either reset
	always_ff @(posedge CLK_SYS_I) begin
		for (int i = 0; i < NCH; i++) begin
			if (rst_all) begin
				input_reg[i] <= odc_pkg::DATA_RESET_VAL;
				data_reg[i]  <= odc_pkg::DATA_RESET_VAL;
				gain_reg[i]  <= odc_pkg::GAIN_RESET_VAL;
				zero_reg[i]  <= odc_pkg::ZERO_RESET_VAL;
			end else begin
				input_reg[i] <= input_next[i];
				data_reg[i]  <= data_next[i];
				gain_reg[i]  <= gain_next[i];
				zero_reg[i]  <= zero_next[i];
			end
		end
	end

	// Flat view of the data registers for the latch bank
	always_comb begin
		data_flat = 96'h0;
		for (int i = 0; i < NCH; i++) begin
			data_flat[i*12 +: 12] = data_reg[i];
		end
	end

	odc_latch_bank u_latches (
		.clk_i       (CLK_SYS_I),
		.rst_i       (rst_all),
		.load_mask_i (load_mask),
		.data_i      (data_flat),
		.latch_o     (LATCH_DATA_O)
	);

	// Every output comes straight from a flip-flop
	assign REG_RDATA_O          = rdata_reg;
	assign REG_RVALID_O         = rvalid_reg;
	assign POWER_DOWN_GROUP_A_O = pd_group_a_reg;
	assign POWER_DOWN_GROUP_B_O = pd_group_b_reg;

endmodule : odc_config_ctrl

`default_nettype wire

/* odc_config_props.sv */
// Checker of the register port and control outputs
`timescale 1ns/1ps
`default_nettype none

module odc_config_props (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_I,
	input wire logic        REG_WR_I,
	input wire logic        REG_RD_I,
	input wire logic [4:0]  REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic [15:0] REG_RDATA_O,
	input wire logic        REG_RVALID_O,
	input wire logic        ASYNC_LATCH_LOAD_PIN_I,
	input wire logic [95:0] LATCH_DATA_O,
	input wire logic        POWER_DOWN_GROUP_A_O,
	input wire logic        POWER_DOWN_GROUP_B_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	// Software reset writes are left out: their fields live one cycle only
	sequence cfg_wr_s;
		REG_WR_I && REG_ADDR_I == 5'h00 && !REG_WDATA_I[13];
	endsequence
	sequence cfg_rd_s;
		REG_RD_I && !REG_WR_I && REG_ADDR_I == 5'h00;
	endsequence

	rvalid_follow_a: assert property (REG_RD_I |=> REG_RVALID_O)
		else $error("read got no valid");
	idle_quiet_a: assert property (
		!REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 16'h0000)
		else $error("read data without read");
	nibble_zero_a: assert property (
		REG_RVALID_O |-> REG_RDATA_O[3:0] == 4'h0)
		else $error("low nibble not zero");
	unmapped_zero_a: assert property (
		REG_RD_I && REG_ADDR_I inside {[5'h01:5'h07]}
		|=> REG_RDATA_O == 16'h0000)
		else $error("unmapped read not zero");
	cfg_unused_a: assert property (
		cfg_rd_s |=> REG_RDATA_O[13] == 1'b0 && REG_RDATA_O[9:0] == 10'h000)
		else $error("unused config bits set");
	pd_group_a_a: assert property (
		cfg_wr_s |=> POWER_DOWN_GROUP_A_O == $past(REG_WDATA_I[12]))
		else $error("group A power-down wrong");
	pd_group_b_a: assert property (
		cfg_wr_s |=> POWER_DOWN_GROUP_B_O == $past(REG_WDATA_I[11]))
		else $error("group B power-down wrong");
	cfg_back_a: assert property (
		cfg_wr_s ##1 cfg_rd_s |=>
		REG_RDATA_O[15] == $past(REG_WDATA_I[15], 2) &&
		REG_RDATA_O[12:10] == $past(REG_WDATA_I[12:10], 2))
		else $error("config readback wrong");
	reset_idle_a: assert property (
		$fell(RST_I) |-> LATCH_DATA_O == 96'h0 &&
		!POWER_DOWN_GROUP_A_O && !POWER_DOWN_GROUP_B_O)
		else $error("outputs not idle after reset");
endmodule : odc_config_props

bind odc_config_ctrl odc_config_props odc_config_props_i (
	.CLK_SYS_I(CLK_SYS_I),
	.RST_I(RST_I),
	.REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I),
	.REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I),
	.REG_RDATA_O(REG_RDATA_O),
	.REG_RVALID_O(REG_RVALID_O),
	.ASYNC_LATCH_LOAD_PIN_I(ASYNC_LATCH_LOAD_PIN_I),
	.LATCH_DATA_O(LATCH_DATA_O),
	.POWER_DOWN_GROUP_A_O(POWER_DOWN_GROUP_A_O),
	.POWER_DOWN_GROUP_B_O(POWER_DOWN_GROUP_B_O)
);

`default_nettype wire

/* odc_host_model.sv */
// Host model driving the register port and the load pin
`timescale 1ns/1ps
`default_nettype none

module odc_host_model (
	// Clock
	input  wire logic   clk_i,
	// Register port
	output logic        wr_o,
	output logic        rd_o,
	output logic [4:0]  addr_o,
	output logic [15:0] wdata_o,
	// Load pin
	output logic        pin_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 5'h00;
		wdata_o = 16'h0000;
		pin_o = 1'b1;
	end

	// Strobe stays up so a following transfer can go back to back
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [15:0] d);
		wr_o = w;
		rd_o = !w;
		addr_o = a;
		wdata_o = d;
		@(posedge clk_i);
		#1;
	endtask : xfer

	// Released lines are inverted so no stale value looks valid
	task automatic idle();
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
		@(posedge clk_i);
		#1;
	endtask : idle

	task automatic pin(input logic v);
		pin_o = v;
	endtask : pin
endmodule : odc_host_model

`default_nettype wire

/* test_octal_dac_config_control.sv */
// Self-checking bench of the configuration control block
`timescale 1ns/1ps
`default_nettype none

module test_octal_dac_config_control;
	logic        clk;
	logic        rst;
	logic        reg_wr;
	logic        reg_rd;
	logic        pin;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid;
	logic [95:0] latch;
	logic        pd_a;
	logic        pd_b;
	int          fails = 0;
	int          total_checks = 0;
	int          seed = 32'hB5B5;
	logic [15:0] exp_q[$];
	logic [11:0] val[8];
	logic [11:0] raw;
	logic [11:0] cor;

	odc_host_model odc_host_model_i (.clk_i(clk), .wr_o(reg_wr), .rd_o(reg_rd),
		.addr_o(addr), .wdata_o(wdata), .pin_o(pin));
	odc_config_ctrl odc_config_ctrl_i (.CLK_SYS_I(clk), .RST_I(rst),
		.REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.ASYNC_LATCH_LOAD_PIN_I(pin), .LATCH_DATA_O(latch),
		.POWER_DOWN_GROUP_A_O(pd_a), .POWER_DOWN_GROUP_B_O(pd_b));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic stop_test();
		// A read that never got its valid leaves its note behind
		if (exp_q.size() != 0) begin
			fails++;
			$display("wrong value at %0t: reads left unanswered", $time);
		end
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic cmp(input logic [95:0] g, input logic [95:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h", $time, g);
		end
	endtask : cmp

	task automatic wrrd(input logic [4:0] a, input logic [15:0] d,
		input logic [15:0] e);
		odc_host_model_i.xfer(1'b1, a, d);
		exp_q.push_back(e);
		odc_host_model_i.xfer(1'b0, a, 16'h0000);
		odc_host_model_i.idle();
	endtask : wrrd

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		odc_host_model_i.xfer(1'b1, a, d);
		odc_host_model_i.idle();
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		odc_host_model_i.xfer(1'b0, a, 16'h0000);
		odc_host_model_i.idle();
	endtask : rd

	// Read answers are matched against the oldest note in the queue
	always @(negedge clk) begin : mon
		logic [15:0] e;
		if (rvalid === 1'b1) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX;
			cmp({80'h0, rdata}, {80'h0, e});
		end
	end

	initial begin
		#100000;
		fails++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		rd(5'h00, 16'h8000);
		for (int c = 0; c < 8; c++) begin
			rd(5'h18 + 5'(c), 16'h8000);
			rd(5'h10 + 5'(c), 16'h0000);
		end
		wrrd(5'h03, 16'hFFF0, 16'h0000);
		wrrd(5'h00, 16'h9BFF, 16'h9800);
		cmp({pd_a, pd_b}, 2'b11);
		rd(5'h10, 16'h0000);
		wrrd(5'h00, 16'h8800, 16'h8800);
		cmp({pd_a, pd_b}, 2'b01);
		for (int c = 0; c < 8; c++) begin
			val[c] = 12'($random(seed));
			wr(5'h08 + 5'(c), {val[c], 4'h0});
		end
		cmp(latch, 96'h0);
		rd(5'h0D, {val[5], 4'h0});
		wr(5'h00, 16'hC000);
		cyc(2);
		for (int c = 0; c < 8; c++) cmp(latch[12*c +: 12], val[c]);
		rd(5'h00, 16'h8000);
		val[2] = 12'($random(seed));
		wr(5'h0A, {val[2], 4'h0});
		odc_host_model_i.pin(1'b0);
		cyc(6);
		for (int c = 0; c < 8; c++) cmp(latch[12*c +: 12], val[c]);
		wrrd(5'h00, 16'hC000, 16'h8000);
		odc_host_model_i.pin(1'b1);
		cyc(4);
		wr(5'h00, 16'h8400);
		wr(5'h19, 16'h4000);
		wr(5'h11, 16'h0100);
		raw = 12'($random(seed));
		cor = (raw >> 1) + 12'h010;
		wr(5'h09, {raw, 4'h0});
		cyc(2);
		rd(5'h09, {cor, 4'h0});
		wrrd(5'h00, 16'h0400, 16'h0400);
		rd(5'h09, {raw, 4'h0});
		wr(5'h00, 16'h4400);
		cyc(3);
		cmp(latch[23:12], cor);
		wr(5'h00, 16'h2000);
		cyc(3);
		rd(5'h00, 16'h8000);
		rd(5'h19, 16'h8000);
		cmp(latch, 96'h0);
		cyc(3);
		stop_test();
	end
endmodule : test_octal_dac_config_control

`default_nettype wire
